/* pkg/lhbp_params.svh */
// Constants of the host bus port: pin positions, reset values, command codes and timing
`ifndef LHBP_PARAMS_SVH
`define LHBP_PARAMS_SVH

// ----------------------------------------------------------------
// Positions in the sampled pin vector
// ----------------------------------------------------------------
`define LHBP_PIN_W      17
`define LHBP_B_D        0
`define LHBP_B_SDA      7
`define LHBP_B_SCK      6
`define LHBP_B_DC       8
`define LHBP_B_RW       9
`define LHBP_B_EN       10
`define LHBP_B_CS       11
`define LHBP_B_INIT     12
`define LHBP_B_PS0      13
`define LHBP_B_PS1      14
`define LHBP_B_DUTY     15
`define LHBP_B_XCK      16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
// Chip deselected, initialisation input released
`define LHBP_PIN_IDLE   17'h0_1800

// ----------------------------------------------------------------
// Command codes and row mapping
// ----------------------------------------------------------------
`define LHBP_CMD_RAM_WR 8'h5C
`define LHBP_CMD_RAM_RD 8'h5D
`define LHBP_ROW_LO_END 7'h21
`define LHBP_ROW_HI_BEG 7'h2E
`define LHBP_ROW_LAST   7'h4F
`define LHBP_ROW_SKIP   7'h0C

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LHBP_BUSY_HOLD  4'h4

`endif

/* pkg/lhbp_pkg.sv */
// Types shared by the host bus port modules
package lhbp_pkg;

    // Host interface selected by the two straps
    typedef enum logic [1:0] {
        LHBP_SPI4,
        LHBP_I80,
        LHBP_SPI3,
        LHBP_M68
    } lhbp_mode_t;

    // Whole state of the port
    typedef struct packed {
        logic [16:0] s1;
        logic [16:0] s2;
        logic [16:0] s3;
        logic [16:0] filt;
        logic [16:0] prev;
        logic [3:0]  bitcnt;
        logic [8:0]  shreg;
        logic        push_v;
        logic        push_dc;
        logic [7:0]  push_byte;
        logic        rd_req;
        logic        rd_is_data;
        logic [7:0]  rd_latch;
        logic [7:0]  data_out;
        logic        data_oe;
        logic        busy;
        logic [3:0]  hold;
        logic [6:0]  mem_row;
        logic        row_valid;
        logic        osc_tick;
        logic        core_init;
    } lhbp_state_t;

endpackage

/* src/lhbp_fifo2.sv */
// Small shifting buffer with valid and ready on both sides
`timescale 1ns/100ps
module lhbp_fifo2 #(
    parameter int W     = 9,
    parameter int DEPTH = 2
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import lhbp_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [DEPTH-1:0]        vld;
    } lhbp_fifo_t;

    lhbp_fifo_t q;
    lhbp_fifo_t n;
    logic       pop;
    logic       push;
    logic       placed;

    // Head sits in slot 0, so the outputs are flops
    assign out_valid = q.vld[0];
    assign out_data  = q.mem[0];
    assign in_ready  = ~q.vld[DEPTH-1];
    assign pop       = q.vld[0] & out_ready;
    assign push      = in_valid & ~q.vld[DEPTH-1];

    // Shift on pop, then write into the first free slot
    always_comb begin
        n = q;
        placed = 1'b0;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                n.mem[i] = q.mem[i+1];
                n.vld[i] = q.vld[i+1];
            end
            n.vld[DEPTH-1] = 1'b0;
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !placed && !n.vld[i]) begin
                n.mem[i] = in_data;
                n.vld[i] = 1'b1;
                placed = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

/* src/lhbp_port.sv */
// Host bus port: strap-selected parallel and serial front end of the display driver
`timescale 1ns/100ps
`include "lhbp_params.svh"

// What this block does
// - Bus strobes act only while chip select is low.
// - Initialisation input low clears the port's internal state once it has passed the three-stage input sampling.
// - Selector high means memory data, low means command byte.
// - First parallel style: read/write line high reads, low writes.
// - First parallel style: transfer starts on enable rising while selected.
// - Second parallel style: write starts when write strobe falls while selected.
// - Second parallel style: read starts when read strobe falls while selected.
// - Two straps choose among two parallel styles and two serial modes.
// - Read back only in parallel modes; serial modes are write-only.
// - Duty strap picks split 68-row or direct 80-row scan line mapping.
// - Bit 7 is MSB in parallel; serial uses bit 7 data, bit 6 clock.
// - External clock pin used only after the host enables it.
// - Busy high during memory access or graphic work, low when ready.
// - Four-wire: shift on rising clock, bit 7 first, selector taken at eighth.
// - Three-wire: nine bits, selector bit first, then bits 7 to 0.
module lhbp_port #(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       hw_init_pulse_n,
    input  wire logic       dc,
    input  wire logic       rw_wr_n,
    input  wire logic       en_rd_n,
    input  wire logic       bus_sel0,
    input  wire logic       bus_sel1,
    input  wire logic       duty_ratio_sel,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe,
    input  wire logic       ext_osc_io_i,
    output logic            ext_osc_io_o,
    output logic            ext_osc_io_oe,
    input  wire logic       ext_clk_en,
    input  wire logic       int_osc_tick,
    output logic            osc_tick,
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic            wr_is_data,
    output logic [7:0]      wr_byte,
    output logic            rd_req,
    output logic            rd_is_data,
    input  wire logic       rd_ack,
    input  wire logic [7:0] rd_data,
    input  wire logic       core_busy,
    output logic            busy,
    input  wire logic [6:0] panel_scan_line,
    output logic [6:0]      mem_row,
    output logic            row_valid,
    output logic            core_init,
    output lhbp_pkg::lhbp_mode_t mode
);
    import lhbp_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic lhbp_mode_t mode_of(input logic ps1, input logic ps0);
        unique case ({ps1, ps0})
            2'b01: mode_of = LHBP_I80;
            2'b11: mode_of = LHBP_M68;
            2'b10: mode_of = LHBP_SPI3;
            2'b00: mode_of = LHBP_SPI4;
        endcase
    endfunction

    // Commands that touch frame memory keep the port busy
    function automatic logic holds_busy(input logic is_data, input logic [7:0] b);
        holds_busy = is_data | (b == `LHBP_CMD_RAM_WR) | (b == `LHBP_CMD_RAM_RD);
    endfunction

    // Scan line to memory row, valid bit on top
    function automatic logic [7:0] row_of(input logic [6:0] line, input logic split);
        if (split) begin
            if (line <= `LHBP_ROW_LO_END) begin
                row_of = {1'b1, line};
            end else if (line >= `LHBP_ROW_HI_BEG && line <= `LHBP_ROW_LAST) begin
                row_of = {1'b1, 7'(line - `LHBP_ROW_SKIP)};
            end else begin
                row_of = 8'h00;
            end
        end else begin
            row_of = {line <= `LHBP_ROW_LAST, line};
        end
    endfunction

    // ----------------------------------------------------------------
    // State and working signals
    // ----------------------------------------------------------------
    lhbp_state_t      q;
    lhbp_state_t      n;
    lhbp_mode_t       cur_mode;
    logic [16:0]      pins;
    logic [16:0]      rise;
    logic [16:0]      fall;
    logic             sel;
    logic             wr_go;
    logic             wr_dc;
    logic [7:0]       wr_b;
    logic             rd_go;
    logic             accept;
    logic             push_rdy;
    logic [8:0]       fifo_out;
    logic [7:0]       row_word;

    assign pins = {ext_osc_io_i, duty_ratio_sel, bus_sel1, bus_sel0, hw_init_pulse_n,
                   cs_n, en_rd_n, rw_wr_n, dc, data_in};
    assign cur_mode = mode_of(q.filt[`LHBP_B_PS1], q.filt[`LHBP_B_PS0]);
    assign rise = q.filt & ~q.prev;
    assign fall = ~q.filt & q.prev;
    assign sel  = ~q.filt[`LHBP_B_CS];
    assign row_word = row_of(panel_scan_line, q.filt[`LHBP_B_DUTY]);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        wr_go = 1'b0;
        wr_dc = q.filt[`LHBP_B_DC];
        wr_b  = q.filt[`LHBP_B_D +: 8];
        rd_go = 1'b0;

        // Three-stage sampling; a change counts once stages two and three agree
        n.s1   = pins;
        n.s2   = q.s1;
        n.s3   = q.s2;
        n.filt = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
        n.prev = q.filt;

        // Strobe decode per interface
        unique case (cur_mode)
            LHBP_M68: begin
                if (sel && rise[`LHBP_B_EN]) begin
                    wr_go = ~q.filt[`LHBP_B_RW];
                    rd_go = q.filt[`LHBP_B_RW];
                end
                n.data_oe = sel & q.filt[`LHBP_B_EN] & q.filt[`LHBP_B_RW];
            end
            LHBP_I80: begin
                wr_go = sel & fall[`LHBP_B_RW];
                rd_go = sel & fall[`LHBP_B_EN];
                n.data_oe = sel & ~q.filt[`LHBP_B_EN];
            end
            LHBP_SPI4, LHBP_SPI3: begin
                n.data_oe = 1'b0;
                if (!sel) begin
                    n.bitcnt = 4'h0;
                    n.shreg  = 9'h000;
                end else if (rise[`LHBP_B_SCK]) begin
                    n.shreg  = {q.shreg[7:0], q.filt[`LHBP_B_SDA]};
                    n.bitcnt = q.bitcnt + 4'h1;
                    wr_b     = {q.shreg[6:0], q.filt[`LHBP_B_SDA]};
                    if (cur_mode == LHBP_SPI4 && q.bitcnt == 4'h7) begin
                        wr_go    = 1'b1;
                        n.bitcnt = 4'h0;
                    end
                    if (cur_mode == LHBP_SPI3 && q.bitcnt == 4'h8) begin
                        wr_go    = 1'b1;
                        wr_dc    = q.shreg[7];
                        n.bitcnt = 4'h0;
                    end
                end
            end
        endcase

        // Written byte waits in the hand-off register until the buffer takes it
        if (q.push_v && push_rdy) begin
            n.push_v = 1'b0;
        end
        if (wr_go) begin
            n.push_v    = 1'b1;
            n.push_dc   = wr_dc;
            n.push_byte = wr_b;
        end

        // Read: present the byte fetched last time, fetch the next one
        n.rd_req = rd_go;
        if (rd_go) begin
            n.data_out   = q.rd_latch;
            n.rd_is_data = q.filt[`LHBP_B_DC];
        end
        if (rd_ack) begin
            n.rd_latch = rd_data;
        end

        // Busy rises with the accepting edge and holds while the LHBP_BUSY_HOLD count runs down, the core is busy or a byte waits
        accept = (wr_go & holds_busy(wr_dc, wr_b)) | (rd_go & q.filt[`LHBP_B_DC]);
        if (accept) begin
            n.hold = `LHBP_BUSY_HOLD;
        end else if (q.hold != 4'h0) begin
            n.hold = q.hold - 4'h1;
        end
        n.busy = accept | (q.hold != 4'h0) | core_busy | n.push_v;

        // Scan line mapping and clock source
        n.mem_row   = row_word[6:0];
        n.row_valid = row_word[7];
        n.core_init = ~q.filt[`LHBP_B_INIT];
        n.osc_tick  = (ext_clk_en && q.filt[`LHBP_B_INIT]) ? rise[`LHBP_B_XCK] : int_osc_tick;

        // Initialisation input low clears the functional state
        if (!q.filt[`LHBP_B_INIT]) begin
            n.bitcnt   = 4'h0;
            n.shreg    = 9'h000;
            n.push_v   = 1'b0;
            n.rd_req   = 1'b0;
            n.rd_latch = 8'h00;
            n.data_oe  = 1'b0;
            n.busy     = 1'b0;
            n.hold     = 4'h0;
            n.osc_tick = int_osc_tick;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            q      <= '0;
            q.s1   <= `LHBP_PIN_IDLE;
            q.s2   <= `LHBP_PIN_IDLE;
            q.s3   <= `LHBP_PIN_IDLE;
            q.filt <= `LHBP_PIN_IDLE;
            q.prev <= `LHBP_PIN_IDLE;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // Write buffer toward the command decoder and frame memory
    // ----------------------------------------------------------------
    lhbp_fifo2 #(
        .W     (9),
        .DEPTH (FIFO_DEPTH)
    ) u_buf (
        .clock     (clock),
        .rst       (rst | ~q.filt[`LHBP_B_INIT]),
        .in_valid  (q.push_v),
        .in_ready  (push_rdy),
        .in_data   ({q.push_dc, q.push_byte}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out)
    );

    // Outputs straight from flops, except the mode decode and the clock pin output and enable, which are tied low
    assign wr_is_data    = fifo_out[8];
    assign wr_byte       = fifo_out[7:0];
    assign data_out      = q.data_out;
    assign data_oe       = q.data_oe;
    assign rd_req        = q.rd_req;
    assign rd_is_data    = q.rd_is_data;
    assign busy          = q.busy;
    assign mem_row       = q.mem_row;
    assign row_valid     = q.row_valid;
    assign osc_tick      = q.osc_tick;
    assign core_init     = q.core_init;
    assign ext_osc_io_o  = 1'b0;
    assign ext_osc_io_oe = 1'b0;
    assign mode          = cur_mode;
endmodule

/* verification/lhbp_host_model.sv */
// Host microcontroller model driving the port's bus pins
`timescale 1ns/100ps
module lhbp_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            cs_n,
    output logic            dc,
    output logic            rw_wr_n,
    output logic            en_rd_n,
    output logic [7:0]      data_in
);
    // Idle bus: deselected, strobes inactive
    initial begin
        cs_n = 1'b1;
        dc = 1'b0;
        rw_wr_n = 1'b1;
        en_rd_n = 1'b1;
        data_in = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Parallel transfer in either strobe style, read data taken at strobe end
    task automatic par_xfer(input logic sel, input logic m68, input logic rd, input logic d,
                            input logic [7:0] b, output logic [7:0] q, output logic oe);
        rw_wr_n = m68 ? rd : 1'b1;
        en_rd_n = !m68;
        step(4);
        cs_n = !sel;
        dc = d;
        data_in = rd ? ~data_in : b;
        step(8);
        rw_wr_n = rd;
        en_rd_n = m68 | !rd;
        step(8);
        q = data_out;
        oe = data_oe;
        rw_wr_n = m68 ? rd : 1'b1;
        en_rd_n = !m68;
        step(6);
        cs_n = 1'b1;
        data_in = ~data_in;           // Released bus shows the inverse
        step(4);
    endtask

    // Serial frame of n clocks, 160 ns clock, MSB first; clock stands still outside
    task automatic ser_xfer(input logic three, input logic d, input logic [7:0] b, input int n);
        logic [8:0] w;
        w = {d, b};
        cs_n = 1'b0;
        dc = d;
        data_in = 8'h3F;
        step(8);
        for (int i = 0; i < n; i++) begin
            data_in[7] = three ? w[8 - i] : w[7 - i];
            step(10);
            data_in[6] = 1'b1;
            step(10);
            data_in[6] = 1'b0;
        end
        step(6);
        cs_n = 1'b1;
        data_in[7] = ~data_in[7];
        step(6);
    endtask
endmodule

/* verification/lhbp_port_properties.sv */
// Concurrent checks on the host bus port, seen from its top ports
`timescale 1ns/100ps
module lhbp_port_properties (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 cs_n,
    input  wire logic                 hw_init_pulse_n,
    input  wire logic                 ext_clk_en,
    input  wire logic                 int_osc_tick,
    input  wire logic                 osc_tick,
    input  wire logic                 wr_valid,
    input  wire logic                 wr_ready,
    input  wire logic                 wr_is_data,
    input  wire logic [7:0]           wr_byte,
    input  wire logic                 rd_req,
    input  wire logic                 rd_is_data,
    input  wire logic                 data_oe,
    input  wire logic                 core_busy,
    input  wire logic                 busy,
    input  wire logic [6:0]           panel_scan_line,
    input  wire logic [6:0]           mem_row,
    input  wire logic                 row_valid,
    input  wire logic                 core_init,
    input  wire lhbp_pkg::lhbp_mode_t mode
);
    import lhbp_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_cs_quiet; cs_n [*8] |-> !rd_req && !$rose(wr_valid); endproperty
    property p_init; $fell(hw_init_pulse_n) |-> ##[2:7] core_init; endproperty
    property p_serial_ro; (mode == LHBP_SPI4 || mode == LHBP_SPI3) && $stable(mode) |-> !data_oe && !rd_req;
    endproperty
    property p_row_low; panel_scan_line <= 7'h21 |=> row_valid && mem_row == $past(panel_scan_line); endproperty
    property p_rd_pulse; rd_req |=> !rd_req; endproperty
    // Only data bytes and the memory commands hold busy; other commands pass straight on
    property p_busy_accept; $rose(wr_valid) && (wr_is_data || wr_byte == 8'h5C || wr_byte == 8'h5D) |-> busy;
    endproperty
    property p_busy_hold; rd_req && rd_is_data |-> busy [*4]; endproperty
    property p_core_busy; core_busy |=> busy; endproperty
    property p_wr_stand; wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte) && $stable(wr_is_data); endproperty
    property p_osc; !ext_clk_en |=> osc_tick == $past(int_osc_tick); endproperty

    // Assertions
    a_cs_quiet: assert property (p_cs_quiet) else $error("bus acted while deselected");
    a_init: assert property (p_init) else $error("init input not seen by core");
    a_serial_ro: assert property (p_serial_ro) else $error("read activity in serial mode");
    a_row_low: assert property (p_row_low) else $error("low scan line mapped wrongly");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read request longer than one cycle");
    a_busy_accept: assert property (p_busy_accept) else $error("byte passed on while ready");
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped too early");
    a_core_busy: assert property (p_core_busy) else $error("core work not shown as busy");
    a_wr_stand: assert property (p_wr_stand) else $error("stalled byte changed");
    a_osc: assert property (p_osc) else $error("tick not from internal oscillator");

    // Main scenarios
    c_write: cover property ($rose(wr_valid));
    c_read: cover property (rd_req);
    c_init: cover property ($rose(core_init));
endmodule

/* verification/testbench.sv */
// Self-checking bench for the host bus port
`timescale 1ns/100ps
module testbench;
    import lhbp_pkg::*;

    logic clock = 1'b0, rst = 1'b1, hw_init_pulse_n = 1'b1, bus_sel0 = 1'b1, bus_sel1 = 1'b0;
    logic duty_ratio_sel = 1'b0, ext_osc_io_i = 1'b0, ext_clk_en = 1'b0, int_osc_tick = 1'b0;
    logic wr_ready = 1'b1, rd_ack = 1'b0, core_busy = 1'b0, cs_n, dc, rw_wr_n, en_rd_n;
    logic [7:0] data_in, data_out, wr_byte, rd_data = 8'h00, q;
    logic [6:0] panel_scan_line = 7'h00, mem_row;
    logic [1:0] tick_div = 2'h0;
    logic data_oe, ext_osc_io_o, ext_osc_io_oe, osc_tick, wr_valid, wr_is_data, rd_req, rd_is_data;
    logic busy, row_valid, core_init, oe;
    lhbp_mode_t mode;
    logic [8:0] got_q[$];
    int failures = 0;
    int cmp_count = 0;

    lhbp_port dut (.clock(clock), .rst(rst), .cs_n(cs_n), .hw_init_pulse_n(hw_init_pulse_n), .dc(dc),
        .rw_wr_n(rw_wr_n), .en_rd_n(en_rd_n), .bus_sel0(bus_sel0), .bus_sel1(bus_sel1),
        .duty_ratio_sel(duty_ratio_sel), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ext_osc_io_i(ext_osc_io_i), .ext_osc_io_o(ext_osc_io_o), .ext_osc_io_oe(ext_osc_io_oe),
        .ext_clk_en(ext_clk_en), .int_osc_tick(int_osc_tick), .osc_tick(osc_tick), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_is_data(wr_is_data), .wr_byte(wr_byte), .rd_req(rd_req),
        .rd_is_data(rd_is_data), .rd_ack(rd_ack), .rd_data(rd_data), .core_busy(core_busy), .busy(busy),
        .panel_scan_line(panel_scan_line), .mem_row(mem_row), .row_valid(row_valid),
        .core_init(core_init), .mode(mode));
    lhbp_host_model host (.clock(clock), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .dc(dc),
        .rw_wr_n(rw_wr_n), .en_rd_n(en_rd_n), .data_in(data_in));

    // Clocks, oscillator ticks, core fetch answer and written-byte capture
    always #4 clock = ~clock;
    always #80 ext_osc_io_i = ~ext_osc_io_i;
    always @(negedge clock) begin
        tick_div = tick_div + 2'h1;
        int_osc_tick = (tick_div == 2'h0);
        rd_ack = rd_req;
        if (rd_req) rd_data = rd_data + 8'h11;
    end
    always @(posedge clock) if (wr_valid && wr_ready) got_q.push_back({wr_is_data, wr_byte});

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pop(input logic [8:0] exp);
        chk("stream", exp, (got_q.size() != 0) ? got_q.pop_front() : 9'bx);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            if (busy === 1'b0) return;
            @(negedge clock);
        end
        chk("busy wait", 9'h000, 9'h001);
        final_report();
    endtask

    task automatic set_mode(input logic s1, input logic s0);
        lhbp_mode_t exp_m[4] = '{LHBP_SPI4, LHBP_I80, LHBP_SPI3, LHBP_M68};
        bus_sel1 = s1;
        bus_sel0 = s0;
        repeat (8) @(negedge clock);
        chk("mode", 9'(exp_m[{s1, s0}]), 9'(mode));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_write();
        logic [7:0] b;
        for (int m = 0; m < 2; m++) begin
            set_mode(1'(m), 1'b1);
            for (int d = 0; d < 2; d++) begin
                b = 8'hA5 ^ 8'(m * 2 + d);
                wait_idle();
                host.par_xfer(1'b1, 1'(m), 1'b0, 1'(d), b, q, oe);
                chk_pop({1'(d), b});
            end
        end
        wait_idle();
        host.par_xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h5C, q, oe);
        chk_pop({1'b0, 8'h5C});
        host.par_xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h77, q, oe);
        chk("deselected writes", 9'h000, 9'(got_q.size()));
    endtask

    task automatic t_read();
        logic [7:0] exp;
        for (int m = 0; m < 2; m++) begin
            set_mode(1'(m), 1'b1);
            wait_idle();
            host.par_xfer(1'b1, 1'(m), 1'b1, 1'b1, 8'h00, q, oe);
            exp = rd_data;
            wait_idle();
            host.par_xfer(1'b1, 1'(m), 1'b1, 1'b1, 8'h00, q, oe);
            chk("read data", {1'b0, exp}, {1'b0, q});
            chk("read drive", 9'h001, {8'h00, oe});
        end
    endtask

    task automatic t_serial();
        for (int t = 0; t < 2; t++) begin
            set_mode(1'(t), 1'b0);
            host.ser_xfer(1'(t), 1'(t), 8'h3C, 3);
            host.ser_xfer(1'(t), 1'(t), 8'hC6 ^ 8'(t), 8 + t);
            repeat (8) @(negedge clock);
            chk_pop({1'(t), 8'hC6 ^ 8'(t)});
            host.par_xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'h00, q, oe);
            chk("serial drive", 9'h000, {8'h00, oe});
            chk("serial extra", 9'h000, 9'(got_q.size()));
        end
    endtask

    task automatic t_stall();
        set_mode(1'b0, 1'b1);
        wr_ready = 1'b0;
        for (int i = 0; i < 3; i++) host.par_xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h81 + 8'(i), q, oe);
        chk("stalled valid", 9'h001, {8'h00, wr_valid});
        wr_ready = 1'b1;
        repeat (10) @(negedge clock);
        for (int i = 0; i < 3; i++) chk_pop({1'b0, 8'h81 + 8'(i)});
    endtask

    task automatic t_rows();
        logic [6:0] lines[6] = '{7'h00, 7'h21, 7'h22, 7'h2D, 7'h2E, 7'h4F};
        logic [7:0] e;
        for (int u = 1; u >= 0; u--) begin
            duty_ratio_sel = 1'(u);
            repeat (8) @(negedge clock);
            foreach (lines[i]) begin
                panel_scan_line = lines[i];
                repeat (2) @(negedge clock);
                e = (u == 0 || lines[i] <= 7'h21) ? {1'b1, lines[i]} : 8'h00;
                if (u == 1 && lines[i] >= 7'h2E) e = {1'b1, lines[i] - 7'h0C};
                chk("row map", {1'b0, e}, {1'b0, row_valid, row_valid ? mem_row : 7'h00});
            end
        end
    endtask

    task automatic t_misc();
        int n;
        n = 0;
        hw_init_pulse_n = 1'b0;
        repeat (1250) @(negedge clock);
        chk("init core", 9'h003, {7'h00, core_init, !busy});
        hw_init_pulse_n = 1'b1;
        repeat (8) @(negedge clock);
        core_busy = 1'b1;
        repeat (8) @(negedge clock);
        chk("core busy", 9'h001, {8'h00, busy});
        core_busy = 1'b0;
        ext_clk_en = 1'b1;
        repeat (200) begin
            @(negedge clock);
            n += int'(osc_tick);
        end
        ext_clk_en = 1'b0;
        chk("ext ticks", 9'h001, 9'(n >= 9 && n <= 11));
        chk("clock pin quiet", 9'h000, {7'h00, ext_osc_io_oe, ext_osc_io_o});
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        t_write();
        t_read();
        t_serial();
        t_stall();
        t_rows();
        t_misc();
        final_report();
    end
endmodule

bind lhbp_port lhbp_port_properties u_props (.clock(clock), .rst(rst), .cs_n(cs_n),
    .hw_init_pulse_n(hw_init_pulse_n), .ext_clk_en(ext_clk_en), .int_osc_tick(int_osc_tick),
    .osc_tick(osc_tick), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_is_data(wr_is_data),
    .wr_byte(wr_byte), .rd_req(rd_req), .rd_is_data(rd_is_data), .data_oe(data_oe),
    .core_busy(core_busy), .busy(busy),
    .panel_scan_line(panel_scan_line), .mem_row(mem_row), .row_valid(row_valid),
    .core_init(core_init), .mode(mode));
